// File: bench/gsc_src_model.sv
// Far-side model: external count clock and the gate source levels.
// Assumes the bench clock; the external clock is parked low outside bursts.
`timescale 1ns/1ps
module gsc_src_model (
    // Clock
    input wire logic clock_i,
    // Bench control
    input wire logic run_i,
    input wire logic lvl_i,
    // Sources
    output logic ext_clk_o,
    output logic gate_o
);
    logic [1:0] div_ff;
    initial ext_clk_o = 1'b0;
    // Eight-cycle period, so each edge clears even the longer sync path
    always @(posedge clock_i) begin
        div_ff <= run_i ? div_ff + 2'h1 : 2'h0;
        if (!run_i) begin
            ext_clk_o <= 1'b0;
        end else if (div_ff == 2'h3) begin
            ext_clk_o <= !ext_clk_o;
        end
    end
    assign gate_o = lvl_i; // One level feeds every gate source
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the gated sixteen-bit counter.
// Assumes gsc_pkg and gsc_counter are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    gsc_pkg::gsc_ctrl_s ctrl = '0;
    gsc_pkg::gsc_wr_s wr = '0;
    logic ovf_clr = 1'b0, sleep = 1'b0, run = 1'b0, lvl = 1'b0;
    logic ext_clk, gate, ovf, irq, wake;
    logic [7:0] lo, hi;
    logic [15:0] v;
    int fails = 0, checks_done = 0, seed = 89;

    always #20 clock_i = ~clock_i;
    gsc_src_model src (.clock_i(clock_i), .run_i(run), .lvl_i(lvl), .ext_clk_o(ext_clk),
        .gate_o(gate));
    gsc_counter uut (.clock_i(clock_i), .srst_i(srst_i), .ctrl_i(ctrl), .wr_i(wr),
        .ovf_clr_i(ovf_clr), .sleep_i(sleep), .ext_clk_i(ext_clk), .gate_pin_i(gate),
        .companion_timer_overflow_i(gate), .first_comparator_output_i(gate),
        .second_comparator_output_i(gate), .count_low_byte_o(lo), .count_high_byte_o(hi),
        .ovf_flag_o(ovf), .irq_o(irq), .wake_o(wake));

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Count after n ticks at a ratio of two to the power ps
    function automatic logic [15:0] exp_div(input logic [15:0] base, input int n, input int ps);
        return 16'(base + 16'(n >> ps));
    endfunction
    // Loads only while stopped, so a write never meets an increment
    task automatic load(input logic [15:0] val);
        wr <= '{1'b1, 1'b0, val[7:0]};
        tick(1);
        wr <= '{1'b0, 1'b1, val[15:8]};
        tick(1);
        wr <= '0;
        tick(2);
    endtask
    task automatic run_int(input int n);
        ctrl.on <= 1'b1;
        tick(n);
        ctrl.on <= 1'b0;
        tick(4);
    endtask
    task automatic clr_flag;
        ovf_clr <= 1'b1;
        tick(1);
        ovf_clr <= 1'b0;
        tick(2);
    endtask

    initial begin
        tick(8);
        srst_i <= 1'b0;
        tick(1);
        check({hi, lo}, 16'h0000);
        check(16'({ovf, irq, wake}), 16'h0000);
        // Each ratio over a whole multiple of eight cycles
        for (int ps = 0; ps < 4; ps++) begin
            v = 16'($random(seed));
            ctrl.prescale_select <= 2'(ps);
            load(v);
            check({hi, lo}, v);
            run_int(32);
            check({hi, lo}, exp_div(v, 32, ps));
        end
        // Partial prescale left over must vanish on a write
        ctrl.prescale_select <= 2'h3;
        load(16'h1234);
        run_int(5);
        load(16'h1234);
        run_int(4);
        check({hi, lo}, 16'h1234);
        // Every source, polarity and gate level
        ctrl.prescale_select <= 2'h0;
        ctrl.gate_enable_bit <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            ctrl.gate_source_select <= gsc_pkg::gsc_gate_e'(i[1:0]);
            ctrl.gate_polarity_bit <= i[2];
            ctrl.cmp_sync_en <= 1'($random(seed));
            lvl <= i[3] ~^ i[2];
            load(16'h0100);
            run_int(16);
            check({hi, lo}, i[3] ? 16'h0110 : 16'h0100);
        end
        ctrl.gate_enable_bit <= 1'b0;
        sleep <= 1'b1;
        load(16'h0100);
        run_int(16);
        check({hi, lo}, 16'h0100);
        sleep <= 1'b0;
        ctrl.ovf_int_en <= 1'b1;
        clr_flag();
        load(16'hFFF8);
        run_int(8);
        check({hi, lo}, 16'h0000);
        check(16'({ovf, irq}), 16'h0003);
        clr_flag();
        check(16'({ovf, irq}), 16'h0000);
        // Mode switched only while stopped, so no edge is lost or gained
        ctrl.ext_clk_sel <= 1'b1;
        ctrl.cmp_sync_en <= 1'b1;
        for (int sd = 0; sd < 2; sd++) begin
            ctrl.sync_disable_bit <= sd[0];
            sleep <= sd[0];
            load(16'hFFFC);
            ctrl.on <= 1'b1;
            run <= 1'b1;
            // Comparator gate wanders while the external clock runs
            repeat (8) begin
                lvl <= 1'($random(seed));
                tick(8);
            end
            run <= 1'b0;
            tick(8);
            ctrl.on <= 1'b0;
            tick(3);
            check({hi, lo}, 16'h0004);
            check(16'({ovf, wake}), {15'h0001, sd[0]});
            sleep <= 1'b0;
            clr_flag();
        end
        // Reset after a stopped run must drop a set flag and the count
        ctrl.ext_clk_sel <= 1'b0;
        load(16'hFFFF);
        run_int(2);
        check({hi, lo}, 16'h0001);
        srst_i <= 1'b1;
        tick(2);
        srst_i <= 1'b0;
        tick(2);
        check({hi, lo}, 16'h0000);
        check(16'({ovf, irq, wake}), 16'h0000);
        tally_and_finish();
    end

    // Hang guard, far beyond the roughly 800 cycles needed
    initial begin
        #800000;
        fails++;
        tally_and_finish();
    end
endmodule

// File: core/gsc_counter.sv
// Gated sixteen-bit counter with prescaler, gate selection and byte access.
// Assumes pins and comparator outputs are asynchronous; the companion overflow is on-clock.
`timescale 1ns/1ps
module gsc_counter (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Control
    input wire gsc_pkg::gsc_ctrl_s ctrl_i,
    input wire gsc_pkg::gsc_wr_s wr_i,
    input wire logic ovf_clr_i,
    input wire logic sleep_i,
    // External sources
    input wire logic ext_clk_i,
    input wire logic gate_pin_i,
    input wire logic companion_timer_overflow_i,
    input wire logic first_comparator_output_i,
    input wire logic second_comparator_output_i,
    // Status
    output logic [7:0] count_low_byte_o,
    output logic [7:0] count_high_byte_o,
    output logic ovf_flag_o,
    output logic irq_o,
    output logic wake_o
);
    logic [1:0] pin_s;
    logic [1:0] cmp_s;
    logic ext_ff;
    logic ext_d_ff;
    logic [2:0] pre_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic gate_sel;
    logic gate_ok;
    logic tick;
    logic pre_hit;
    logic inc;
    logic wr_any;
    logic run;
    logic ovf_evt;
    logic [1:0] cmp_tick_ff;

    // Prescale terminal test; at or past the limit counts as done, so lowering
    // the ratio with a part count left over cannot wrap through all eight states
    function automatic logic pre_done(input logic [2:0] p, input logic [1:0] sel);
        logic [2:0] lim;
        lim = 3'((4'h1 << sel) - 4'h1);
        return p >= lim;
    endfunction

    // External clock and gate pin cross into the clock domain
    gsc_sync2 #(.W(2)) u_pin_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i({ext_clk_i, gate_pin_i}),
        .q_o(pin_s)
    );

    // Comparator outputs, synchronised copy feeding both gate paths
    gsc_sync2 #(.W(2)) u_cmp_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i({second_comparator_output_i, first_comparator_output_i}),
        .q_o(cmp_s)
    );

    // Synchronised comparator copy moves only on count-source ticks, so the
    // gate level cannot change between two count-source ticks
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cmp_tick_ff <= 2'h0;
        end else if (tick) begin
            cmp_tick_ff <= cmp_s;
        end
    end

    // Extra sync stage; bypassed when sync is disabled, so a mode change may
    // drop or add one edge, which is accepted behaviour
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ext_ff <= 1'b0;
            ext_d_ff <= 1'b0;
        end else begin
            ext_ff <= pin_s[1];
            ext_d_ff <= ctrl_i.sync_disable_bit ? pin_s[1] : ext_ff;
        end
    end

    // Count source tick: rising edge of external clock or every system clock outside sleep
    always_comb begin
        if (ctrl_i.ext_clk_sel) begin
            tick = ctrl_i.sync_disable_bit ? (pin_s[1] & ~ext_d_ff)
                                           : (ext_ff & ~ext_d_ff);
        end else begin
            // Internal clock stops in sleep; external keeps going, synced or not
            tick = ~sleep_i;
        end
    end

    // Gate source selection
    always_comb begin
        unique case (ctrl_i.gate_source_select)
            gsc_pkg::GSC_GATE_PIN: gate_sel = pin_s[0];
            gsc_pkg::GSC_GATE_TMR: gate_sel = companion_timer_overflow_i;
            gsc_pkg::GSC_GATE_CMP1: gate_sel = ctrl_i.cmp_sync_en ? cmp_tick_ff[0]
                                                                 : cmp_s[0];
            gsc_pkg::GSC_GATE_CMP2: gate_sel = ctrl_i.cmp_sync_en ? cmp_tick_ff[1]
                                                                 : cmp_s[1];
        endcase
    end

    // Plain comparator path is faster but may change between two ticks
    assign gate_ok = ~ctrl_i.gate_enable_bit
                   | (gate_sel == ctrl_i.gate_polarity_bit);
    assign run = ctrl_i.on & gate_ok & (~sleep_i | ctrl_i.ext_clk_sel);
    assign wr_any = wr_i.wr_lo | wr_i.wr_hi;
    assign pre_hit = pre_done(pre_ff, ctrl_i.prescale_select);
    assign inc = run & tick & pre_hit;
    // A write in the rollover cycle replaces the count, so no overflow then
    assign ovf_evt = inc & (cnt_ff == 16'hFFFF) & ~wr_any;

    // Prescale counter, hidden from software
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pre_ff <= gsc_pkg::PRE_RST;
        end else if (wr_any) begin
            pre_ff <= gsc_pkg::PRE_RST;
        end else if (run & tick) begin
            pre_ff <= pre_hit ? gsc_pkg::PRE_RST : 3'(pre_ff + 3'h1);
        end
    end

    // Byte writes win over an increment; software is expected to stop first
    always_comb begin
        nxt_cnt = inc ? 16'(cnt_ff + 16'h0001) : cnt_ff;
        if (wr_i.wr_lo) begin
            nxt_cnt[gsc_pkg::BYTE_LO_LSB +: 8] = wr_i.data;
        end
        if (wr_i.wr_hi) begin
            nxt_cnt[gsc_pkg::BYTE_HI_LSB +: 8] = wr_i.data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cnt_ff <= gsc_pkg::CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Read bytes are registered copies, always coherent in the clock domain
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            count_low_byte_o <= 8'h00;
            count_high_byte_o <= 8'h00;
        end else begin
            count_low_byte_o <= cnt_ff[gsc_pkg::BYTE_LO_LSB +: 8];
            count_high_byte_o <= cnt_ff[gsc_pkg::BYTE_HI_LSB +: 8];
        end
    end

    // Overflow flag; a set in the clear cycle wins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ovf_flag_o <= 1'b0;
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            if (ovf_evt) begin
                ovf_flag_o <= 1'b1;
            end else if (ovf_clr_i) begin
                ovf_flag_o <= 1'b0;
            end
            irq_o <= ctrl_i.ovf_int_en & (ovf_flag_o | ovf_evt);
            wake_o <= sleep_i & ctrl_i.ovf_int_en & ovf_flag_o;
        end
    end

    chk_ovf_sets: assert property (@(posedge clock_i) disable iff (srst_i)
        (inc && cnt_ff == 16'hFFFF && !wr_any) |=> ovf_flag_o && cnt_ff == 16'h0000)
        else $error("overflow flag not set on rollover");
    chk_gate_holds: assert property (@(posedge clock_i) disable iff (srst_i)
        (!gate_ok && !wr_any) |=> $stable(cnt_ff))
        else $error("count moved while gate closed");
    chk_write_clears_pre: assert property (@(posedge clock_i) disable iff (srst_i)
        wr_any |=> pre_ff == 3'h0)
        else $error("prescaler not cleared by write");
    chk_div_one: assert property (@(posedge clock_i) disable iff (srst_i)
        (ctrl_i.prescale_select == 2'h0 && run && tick && !wr_any)
        |=> cnt_ff == 16'($past(cnt_ff) + 16'h0001))
        else $error("divide by one did not increment");
    chk_pre_bound: assert property (@(posedge clock_i) disable iff (srst_i)
        (ctrl_i.prescale_select == 2'h3 && pre_ff != 3'h7 && run && tick && !wr_any)
        |=> $stable(cnt_ff) && pre_ff == 3'($past(pre_ff) + 3'h1))
        else $error("divide by eight counted early");
    chk_gate_pin_sel: assert property (@(posedge clock_i) disable iff (srst_i)
        ctrl_i.gate_source_select == gsc_pkg::GSC_GATE_PIN |-> gate_sel == pin_s[0])
        else $error("gate pin not selected");
    chk_gate_tmr_sel: assert property (@(posedge clock_i) disable iff (srst_i)
        ctrl_i.gate_source_select == gsc_pkg::GSC_GATE_TMR
        |-> gate_sel == companion_timer_overflow_i)
        else $error("companion overflow not selected");
    chk_cmp_sync: assert property (@(posedge clock_i) disable iff (srst_i)
        (ctrl_i.gate_source_select[1] && ctrl_i.cmp_sync_en && !tick)
        ##1 (ctrl_i.cmp_sync_en && $stable(ctrl_i.gate_source_select)) |-> $stable(gate_sel))
        else $error("synchronised comparator moved between ticks");
    chk_read_lag: assert property (@(posedge clock_i) disable iff (srst_i)
        ##1 {count_high_byte_o, count_low_byte_o} == $past(cnt_ff))
        else $error("read bytes not coherent");
    chk_sleep_async: assert property (@(posedge clock_i) disable iff (srst_i)
        (sleep_i && !ctrl_i.ext_clk_sel && !wr_any) |=> $stable(cnt_ff))
        else $error("internal clock counted in sleep");
    chk_wake_raised: assert property (@(posedge clock_i) disable iff (srst_i)
        (sleep_i && ctrl_i.ovf_int_en && ovf_flag_o) |=> wake_o)
        else $error("wake not raised on overflow in sleep");
    chk_irq_on_ovf: assert property (@(posedge clock_i) disable iff (srst_i)
        (ovf_evt && ctrl_i.ovf_int_en) |=> irq_o && ovf_flag_o)
        else $error("interrupt not raised on rollover");
endmodule

// File: core/gsc_pkg.sv
// Package for the gated sixteen-bit counter: constants, enums and carrier structs.
// Assumes a single 25 MHz system clock; no register bus, control bits are plain ports.
package gsc_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 3;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [2:0] PRE_RST = 3'h0;
    localparam int BYTE_LO_LSB = 0;
    localparam int BYTE_HI_LSB = 8;

    typedef enum logic [1:0] {
        GSC_GATE_PIN = 2'h0,
        GSC_GATE_TMR = 2'h1,
        GSC_GATE_CMP1 = 2'h2,
        GSC_GATE_CMP2 = 2'h3
    } gsc_gate_e;

    // Control bits gathered as one carrier
    typedef struct packed {
        logic on;
        logic ext_clk_sel;
        logic sync_disable_bit;
        logic [1:0] prescale_select;
        logic gate_enable_bit;
        logic gate_polarity_bit;
        gsc_gate_e gate_source_select;
        logic cmp_sync_en;
        logic ovf_int_en;
    } gsc_ctrl_s;

    // Byte write strobes with data
    typedef struct packed {
        logic wr_lo;
        logic wr_hi;
        logic [7:0] data;
    } gsc_wr_s;
endpackage

// File: core/gsc_sync2.sv
// Two-flop level synchroniser.
// Assumes the input is a level from outside the clock domain.
`timescale 1ns/1ps
module gsc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    // First stage is read only by the second
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_ff <= '0;
            q_o <= '0;
        end else begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule
